// File: include/sdb_regs.svh
`ifndef SDB_REGS_SVH
`define SDB_REGS_SVH

// Access mode setting: field positions
`define SDB_BL_LSB      0
`define SDB_BT_BIT      3
`define SDB_CL_LSB      4
`define SDB_OPLO_BIT    7
`define SDB_OPHI_BIT    8
`define SDB_WB_BIT      9
`define SDB_MODE_RESET  13'h0000

// Burst length and read latency codes
`define SDB_BL_FULL     3'h7
`define SDB_BL_MAXPOW   3'h3
`define SDB_CL_2        3'h2
`define SDB_CL_3        3'h3

// Controller register offsets
`define SDB_REG_MODE    8'h00
`define SDB_REG_ADDR    8'h04
`define SDB_REG_WDATA   8'h08
`define SDB_REG_LEN     8'h0C
`define SDB_REG_CMD     8'h10
`define SDB_REG_STATUS  8'h14
`define SDB_REG_RDATA   8'h18
`define SDB_LEN_RESET   9'h001

// Timing: system clock period and link clock half period in cycles
`define SDB_CLK_NS      8
`define SDB_HALF        4
`define SDB_T_RCD_NS    20
`define SDB_T_RC_NS     70
`define SDB_T_RRD_NS    14
`define SDB_T_MRD_NS    16

`endif

// File: include/sdb_pkg.sv
package sdb_pkg;

    // Link command code, {row strobe, column strobe, write strobe}, all active low
    typedef enum logic [2:0] {
        CMD_LMR  = 3'h0,
        CMD_REF  = 3'h1,
        CMD_PRE  = 3'h2,
        CMD_ACT  = 3'h3,
        CMD_WR   = 3'h4,
        CMD_RD   = 3'h5,
        CMD_TERM = 3'h6,
        CMD_NOP  = 3'h7
    } sdb_cmd_e;

    typedef logic [12:0] sdb_addr_t;
    typedef logic [31:0] sdb_word_t;

endpackage : sdb_pkg

// File: include/sdb_link_if.sv
`timescale 1ns/1ns
`default_nettype none

interface sdb_link_if;
    logic              sdClk;
    logic              csN;
    sdb_pkg::sdb_cmd_e cmdPins;
    sdb_pkg::sdb_addr_t addr;
    logic [1:0]        bankSel;
    sdb_pkg::sdb_word_t devDq;
    logic              devDriveN;
    sdb_pkg::sdb_word_t ctlDq;
    logic              ctlDriveN;
    sdb_pkg::sdb_word_t dq;

    // Shared data wire: the end that enables its driver sets the level, the device if both do
    assign dq = !devDriveN ? devDq : (!ctlDriveN ? ctlDq : '0);

    modport device (
        input  sdClk, csN, cmdPins, addr, bankSel, dq,
        output devDq, devDriveN
    );
    modport ctrl (
        output sdClk, csN, cmdPins, addr, bankSel, ctlDq, ctlDriveN,
        input  dq
    );
endinterface : sdb_link_if

`default_nettype wire

// File: src/sdb_burst_addr.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdb_regs.svh"

module sdb_burst_addr (
    // Burst setup
    input  wire logic [7:0] startCol,
    input  wire logic [7:0] beatIdx,
    input  wire logic [2:0] lenCode,
    input  wire logic       interleave,
    // Column for this beat
    output logic [7:0]      col
);
    // Wrap mask: block size minus one, whole page when full
    wire       fullPage = lenCode == `SDB_BL_FULL;
    wire [7:0] mask     = fullPage ? 8'hFF :
                          (lenCode <= `SDB_BL_MAXPOW) ? 8'((9'h001 << lenCode) - 9'h001) : 8'h00;
    // Offset within block: increment or exclusive OR with the beat count
    wire [7:0] seqOff   = startCol + beatIdx;
    wire [7:0] intOff   = startCol ^ beatIdx;
    wire [7:0] offset   = (interleave && !fullPage) ? intOff : seqOff;

    // Upper bits pick the block, lower bits walk inside it
    assign col = (startCol & ~mask) | (offset & mask);
endmodule : sdb_burst_addr

`default_nettype wire

// File: src/sdb_device.sv
// Summary of operation
// - Burst lengths one, two, four, eight supported
// - Full page only with sequential order
// - Full page runs until burst terminate
// - Burst wraps inside aligned block of length
// - Full page increments, wraps within page
// - Sequential: offset increments modulo length
// - Interleaved: start offset XOR beat count
// - Read latency two or three clocks
// - Drive from edge n+m-1, valid n+m
// - Latency two only up to 100 MHz
// - Operating mode bits must be zero
// - Write burst bit forces single writes
// - Never program reserved codes or tests
// - Activate a row before any access
// - Wait activate-to-access time before access
// - Precharge first, respect same-bank interval
// - Other bank may open during access
// - Mode fields: length, order, latency, op, write
// - Load mode only when all idle
// - Bank and row, then column address
`timescale 1ns/1ns
`default_nettype none
`include "sdb_regs.svh"

module sdb_device #(
    parameter int ROW_BITS = 11
) (
    // Clock and reset
    input  wire logic   clock,
    input  wire logic   rst,
    // Link to the controller
    sdb_link_if.device  lnk,
    // Local status
    output logic [12:0] modeSetting,
    output logic [3:0]  bankOpen,
    output logic        burstBusy
);
    import sdb_pkg::*;

    localparam int MEM_AW = 2 + ROW_BITS + 8;
    localparam int PIN_W  = 52;

    // Refuse row widths the row field cannot carry
    if (ROW_BITS < 1 || ROW_BITS > 11)
    begin : g_bad_rows
        $error("ROW_BITS must lie between 1 and 11");
    end

    logic [PIN_W-1:0]    pinsA_q;
    logic [PIN_W-1:0]    pinsB_q;
    logic                clkSeen_q;
    logic [12:0]         mode_q;
    logic [3:0]          rowOpen_q;
    logic [ROW_BITS-1:0] openRow_q [4];
    logic                bActive_q;
    logic                bWrite_q;
    logic                bFull_q;
    logic [1:0]          bBank_q;
    logic [ROW_BITS-1:0] bRow_q;
    logic [7:0]          bStart_q;
    logic [7:0]          bIdx_q;
    logic [8:0]          bBeats_q;
    logic [1:0]          rdV_q;
    logic [MEM_AW-1:0]   rdA_q [2];
    logic                driveN_q;
    logic [31:0]         devDq_q;
    logic [31:0]         mem [2**MEM_AW];
    logic [7:0]          colNow;
    sdb_cmd_e            cmdS;

    // Two flip-flops on every link pin, link clock included
    wire [PIN_W-1:0] pinsRaw = {lnk.sdClk, lnk.csN, lnk.cmdPins, lnk.addr, lnk.bankSel, lnk.dq};

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pinsA_q   <= '0;
            pinsB_q   <= '0;
            clkSeen_q <= 1'b0;
        end
        else
        begin
            pinsA_q   <= pinsRaw;
            pinsB_q   <= pinsA_q;
            clkSeen_q <= pinsB_q[PIN_W-1];
        end
    end

    // Link edge and command decode
    wire        linkRise = pinsB_q[PIN_W-1] & ~clkSeen_q;
    wire        selS     = linkRise & ~pinsB_q[50];
    assign cmdS = sdb_cmd_e'(pinsB_q[49:47]);
    wire [12:0] addrS    = pinsB_q[46:34];
    wire [1:0]  bankS    = pinsB_q[33:32];
    wire [31:0] dqS      = pinsB_q[31:0];
    wire        isLoad   = selS && cmdS == CMD_LMR;
    wire        isAct    = selS && cmdS == CMD_ACT;
    wire        isPre    = selS && cmdS == CMD_PRE;
    wire        isRd     = selS && cmdS == CMD_RD;
    wire        isWr     = selS && cmdS == CMD_WR;
    wire        isTerm   = selS && cmdS == CMD_TERM;

    // Mode fields
    wire [2:0]  lenCode  = mode_q[`SDB_BL_LSB +: 3];
    wire        interlv  = mode_q[`SDB_BT_BIT];
    wire [2:0]  latCode  = mode_q[`SDB_CL_LSB +: 3];
    wire        singleWr = mode_q[`SDB_WB_BIT];
    wire        fullPage = lenCode == `SDB_BL_FULL;
    wire        lat3     = latCode == `SDB_CL_3;
    wire [8:0]  lenBeats = (lenCode <= `SDB_BL_MAXPOW) ? (9'h001 << lenCode) : 9'h001;

    // Access setup; an access to a closed bank is ignored
    wire        accOk    = (isRd | isWr) & rowOpen_q[bankS];
    wire        wrOne    = isWr & singleWr;
    wire [8:0]  accBeats = wrOne ? 9'h001 : lenBeats;
    wire        accFull  = fullPage & ~wrOne;

    // Beat in progress at this link edge, new command or running burst
    wire        stopNow  = isTerm | (isPre & (addrS[10] | (bankS == bBank_q)));
    wire        beatNow  = accOk | (bActive_q & linkRise & ~stopNow);
    wire [7:0]  idxNow   = accOk ? 8'h00 : bIdx_q;
    wire [7:0]  startNow = accOk ? addrS[7:0] : bStart_q;
    wire [1:0]  bankNow  = accOk ? bankS : bBank_q;
    wire [ROW_BITS-1:0] rowNow = accOk ? openRow_q[bankS] : bRow_q;
    wire        writeNow = accOk ? isWr : bWrite_q;
    wire [MEM_AW-1:0] memAddr = {bankNow, rowNow, colNow};
    wire [7:0]  nextIdx  = bIdx_q + 8'h01;
    wire        lastBeat = !bFull_q && ({1'b0, nextIdx} == bBeats_q);

    // Column sequence generator
    sdb_burst_addr u_burst_addr (
        .startCol   (startNow),
        .beatIdx    (idxNow),
        .lenCode    (lenCode),
        .interleave (interlv),
        .col        (colNow)
    );

    // Mode setting store
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            mode_q <= `SDB_MODE_RESET;
        else if (isLoad)
            mode_q <= addrS;
    end

    // Per-bank open row tracking
    for (genvar b = 0; b < 4; b++)
    begin : g_bank
        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                rowOpen_q[b] <= 1'b0;
                openRow_q[b] <= '0;
            end
            else if (isAct && bankS == 2'(b))
            begin
                rowOpen_q[b] <= 1'b1;
                openRow_q[b] <= addrS[ROW_BITS-1:0];
            end
            else if (isPre && (addrS[10] || bankS == 2'(b)))
                rowOpen_q[b] <= 1'b0;
        end
    end

    // Burst counter: starts on an access, stops at length, terminate or precharge of its bank
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            bActive_q <= 1'b0;
            bWrite_q  <= 1'b0;
            bFull_q   <= 1'b0;
            bBank_q   <= 2'h0;
            bRow_q    <= '0;
            bStart_q  <= 8'h00;
            bIdx_q    <= 8'h00;
            bBeats_q  <= 9'h001;
        end
        else if (accOk)
        begin
            bActive_q <= accFull || accBeats != 9'h001;
            bWrite_q  <= isWr;
            bFull_q   <= accFull;
            bBank_q   <= bankS;
            bRow_q    <= openRow_q[bankS];
            bStart_q  <= addrS[7:0];
            bIdx_q    <= 8'h01;
            bBeats_q  <= accBeats;
        end
        else if (bActive_q && linkRise)
        begin
            if (stopNow || lastBeat)
                bActive_q <= 1'b0;
            bIdx_q <= nextIdx;
        end
    end

    // Write data taken at each write beat
    always_ff @(posedge clock)
    begin
        if (beatNow && writeNow)
            mem[memAddr] <= dqS;
    end

    // Read pipeline, one stage per link clock; a write clears it
    wire wrCut = accOk & isWr;
    wire outV  = lat3 ? rdV_q[1] : rdV_q[0];
    wire [MEM_AW-1:0] outA = lat3 ? rdA_q[1] : rdA_q[0];

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rdV_q    <= 2'b00;
            rdA_q[0] <= '0;
            rdA_q[1] <= '0;
        end
        else if (linkRise)
        begin
            rdV_q    <= wrCut ? 2'b00 : {rdV_q[0], beatNow & ~writeNow};
            rdA_q[0] <= memAddr;
            rdA_q[1] <= rdA_q[0];
        end
    end

    // Output driver turns on after edge n+m-1, valid before edge n+m
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            driveN_q <= 1'b1;
            devDq_q  <= '0;
        end
        else if (linkRise)
        begin
            driveN_q <= ~(outV & ~wrCut);
            if (outV)
                devDq_q <= mem[outA];
        end
    end

    // Pins and local status
    assign lnk.devDq     = devDq_q;
    assign lnk.devDriveN = driveN_q;
    assign modeSetting   = mode_q;
    assign bankOpen      = rowOpen_q;
    assign burstBusy     = bActive_q;
endmodule : sdb_device

`default_nettype wire

// File: src/sdb_controller.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdb_regs.svh"

module sdb_controller #(
    parameter int HALF = `SDB_HALF
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Link to the device
    sdb_link_if.ctrl         lnk,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [31:0]      regRdata
);
    import sdb_pkg::*;

    localparam int LINK_NS = 2 * HALF * `SDB_CLK_NS;
    localparam logic [3:0] RCD_CYC = 4'((`SDB_T_RCD_NS + LINK_NS - 1) / LINK_NS);
    localparam logic [3:0] RC_CYC  = 4'((`SDB_T_RC_NS + LINK_NS - 1) / LINK_NS);
    localparam logic [3:0] RRD_CYC = 4'((`SDB_T_RRD_NS + LINK_NS - 1) / LINK_NS);
    localparam logic [3:0] MRD_CYC = 4'((`SDB_T_MRD_NS + LINK_NS - 1) / LINK_NS);

    // Half period must cover the pin synchronisers at both ends
    if (HALF < 4 || HALF > 127)
    begin : g_bad_half
        $error("HALF must lie between 4 and 127");
    end

    logic [7:0]  div_q;
    logic        sdClk_q;
    logic [31:0] dqA_q;
    logic [31:0] dqB_q;
    logic [12:0] mode_q;
    logic [12:0] actMode_q;
    logic [14:0] addrReg_q;
    logic [31:0] wdata_q;
    logic [8:0]  len_q;
    logic        pend_q;
    sdb_cmd_e    pendCmd_q;
    logic [3:0]  bankOpen_q;
    logic [3:0]  rcT_q [4];
    logic [3:0]  rcdT_q [4];
    logic [3:0]  rrdT_q;
    logic [3:0]  mrdT_q;
    logic        csN_q;
    sdb_cmd_e    cmd_q;
    logic [12:0] addr_q;
    logic [1:0]  bank_q;
    logic [31:0] ctlDq_q;
    logic        ctlDriveN_q;
    logic [8:0]  beatsLeft_q;
    logic        burstOn_q;
    logic        burstFull_q;
    logic [2:0]  rdDelay_q;
    logic [8:0]  rdLeft_q;
    logic [31:0] rdata_q;
    logic [8:0]  rdCount_q;
    logic [31:0] regRdata_q;

    // Link clock divider; commands change on the falling edge
    wire riseTick = div_q == 8'(2 * HALF - 1);
    wire fallTick = div_q == 8'(HALF - 1);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            div_q   <= 8'h00;
            sdClk_q <= 1'b0;
            dqA_q   <= '0;
            dqB_q   <= '0;
        end
        else
        begin
            div_q   <= riseTick ? 8'h00 : div_q + 8'h01;
            sdClk_q <= riseTick ? 1'b1 : (fallTick ? 1'b0 : sdClk_q);
            dqA_q   <= lnk.dq;
            dqB_q   <= dqA_q;
        end
    end

    // Register decode and order checks
    wire       busy    = pend_q | burstOn_q | (rdLeft_q != 9'h000) | (rdDelay_q != 3'h0);
    wire [1:0] tgtBank = addrReg_q[14:13];
    wire [2:0] lenSet  = mode_q[`SDB_BL_LSB +: 3];
    wire [2:0] latSet  = mode_q[`SDB_CL_LSB +: 3];
    wire       lenOk   = lenSet <= `SDB_BL_MAXPOW || (lenSet == `SDB_BL_FULL && !mode_q[`SDB_BT_BIT]);
    wire       modeOk  = lenOk && (latSet == `SDB_CL_2 || latSet == `SDB_CL_3);
    wire       isAcc   = pendCmd_q == CMD_RD || pendCmd_q == CMD_WR;
    wire       tgtOpen = bankOpen_q[tgtBank];
    wire       okAct   = !tgtOpen && rcT_q[tgtBank] == 4'h0 && rrdT_q == 4'h0;
    wire       okAcc   = tgtOpen && rcdT_q[tgtBank] == 4'h0;
    wire       okLoad  = bankOpen_q == 4'h0 && modeOk;
    wire       ready   = mrdT_q == 4'h0 && ((pendCmd_q == CMD_ACT && okAct) ||
                         (isAcc && okAcc) || pendCmd_q == CMD_PRE ||
                         (pendCmd_q == CMD_LMR && okLoad));
    wire       go      = fallTick && pend_q && ready;
    wire       dropIt  = fallTick && pend_q && !ready && ((isAcc && !tgtOpen) ||
                         (pendCmd_q == CMD_ACT && tgtOpen) ||
                         (pendCmd_q == CMD_LMR && !okLoad) || pendCmd_q == CMD_REF ||
                         pendCmd_q == CMD_TERM || pendCmd_q == CMD_NOP);
    wire       goAct   = go && pendCmd_q == CMD_ACT;
    wire       goPre   = go && pendCmd_q == CMD_PRE;
    wire       goRd    = go && pendCmd_q == CMD_RD;
    wire       goWr    = go && pendCmd_q == CMD_WR;
    wire       goLoad  = go && pendCmd_q == CMD_LMR;
    wire [12:0] loadVal = {mode_q[12:9], 2'b00, mode_q[6:0]};
    wire       wrFull  = actMode_q[2:0] == `SDB_BL_FULL && !(goWr && actMode_q[`SDB_WB_BIT]);

    // Software registers
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            mode_q    <= `SDB_MODE_RESET;
            addrReg_q <= '0;
            wdata_q   <= '0;
            len_q     <= `SDB_LEN_RESET;
            pend_q    <= 1'b0;
            pendCmd_q <= CMD_NOP;
        end
        else
        begin
            if (regWr && regAddr == `SDB_REG_MODE)
                mode_q <= regWdata[12:0];
            if (regWr && regAddr == `SDB_REG_ADDR)
                addrReg_q <= regWdata[14:0];
            if (regWr && regAddr == `SDB_REG_WDATA)
                wdata_q <= regWdata;
            if (regWr && regAddr == `SDB_REG_LEN)
                len_q <= regWdata[8] ? 9'h100 : (regWdata[7:0] == 8'h00 ? 9'h001 : regWdata[8:0]);
            if (regWr && regAddr == `SDB_REG_CMD && !busy)
            begin
                pend_q    <= 1'b1;
                pendCmd_q <= sdb_cmd_e'(regWdata[2:0]);
            end
            else if (go || dropIt)
                pend_q <= 1'b0;
        end
    end

    // Per-bank state and timers, counted in link clocks
    for (genvar b = 0; b < 4; b++)
    begin : g_bank
        wire actHere = goAct && tgtBank == 2'(b);
        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
            begin
                bankOpen_q[b] <= 1'b0;
                rcT_q[b]      <= 4'h0;
                rcdT_q[b]     <= 4'h0;
            end
            else
            begin
                if (actHere)
                    bankOpen_q[b] <= 1'b1;
                else if (goPre && (addrReg_q[10] || tgtBank == 2'(b)))
                    bankOpen_q[b] <= 1'b0;
                rcT_q[b]  <= actHere ? RC_CYC : rcT_q[b] - 4'(riseTick && rcT_q[b] != 4'h0);
                rcdT_q[b] <= actHere ? RCD_CYC : rcdT_q[b] - 4'(riseTick && rcdT_q[b] != 4'h0);
            end
        end
    end

    // Cross-bank and mode-load spacing
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rrdT_q    <= 4'h0;
            mrdT_q    <= 4'h0;
            actMode_q <= `SDB_MODE_RESET;
        end
        else
        begin
            rrdT_q <= goAct ? RRD_CYC : rrdT_q - 4'(riseTick && rrdT_q != 4'h0);
            mrdT_q <= goLoad ? MRD_CYC : mrdT_q - 4'(riseTick && mrdT_q != 4'h0);
            if (goLoad)
                actMode_q <= loadVal;
        end
    end

    // Command, address and write data driven at each falling edge
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            csN_q <= 1'b1;
            cmd_q <= CMD_NOP;
            addr_q <= '0;
            bank_q <= 2'h0;
            ctlDq_q <= '0;
            ctlDriveN_q <= 1'b1;
            beatsLeft_q <= 9'h000;
            burstOn_q <= 1'b0;
            burstFull_q <= 1'b0;
        end
        else if (fallTick)
        begin
            csN_q <= ~go;
            cmd_q <= go ? pendCmd_q : CMD_NOP;
            if (go)
            begin
                addr_q <= goLoad ? loadVal : addrReg_q[12:0];
                bank_q <= tgtBank;
                ctlDq_q <= wdata_q;
                ctlDriveN_q <= ~goWr;
                beatsLeft_q <= isAcc ? len_q - 9'h001 : 9'h000;
                burstOn_q <= isAcc;
                burstFull_q <= wrFull;
            end
            else if (beatsLeft_q != 9'h000)
            begin
                ctlDq_q <= ctlDq_q + 32'h1;
                beatsLeft_q <= beatsLeft_q - 9'h001;
            end
            else if (burstOn_q)
            begin
                csN_q <= ~burstFull_q;
                cmd_q <= CMD_TERM;
                ctlDriveN_q <= 1'b1;
                burstOn_q <= 1'b0;
            end
        end
    end

    // Read capture: first word sampled just before edge n+m
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rdDelay_q <= 3'h0;
            rdLeft_q  <= 9'h000;
            rdata_q   <= '0;
            rdCount_q <= 9'h000;
        end
        else if (goRd)
        begin
            rdDelay_q <= actMode_q[`SDB_CL_LSB +: 3];
            rdLeft_q  <= len_q;
            rdCount_q <= 9'h000;
        end
        else if (riseTick && rdDelay_q != 3'h0)
            rdDelay_q <= rdDelay_q - 3'h1;
        else if (riseTick && rdLeft_q != 9'h000)
        begin
            rdata_q   <= dqB_q;
            rdLeft_q  <= rdLeft_q - 9'h001;
            rdCount_q <= rdCount_q + 9'h001;
        end
    end

    // Register read data, valid one cycle after the strobe
    wire [31:0] rdMux =
        (regAddr == `SDB_REG_MODE)   ? {19'h0, mode_q} :
        (regAddr == `SDB_REG_ADDR)   ? {17'h0, addrReg_q} :
        (regAddr == `SDB_REG_WDATA)  ? wdata_q :
        (regAddr == `SDB_REG_LEN)    ? {23'h0, len_q} :
        (regAddr == `SDB_REG_STATUS) ? {7'h00, rdCount_q, 8'h00, bankOpen_q, 3'h0, busy} :
        (regAddr == `SDB_REG_RDATA)  ? rdata_q : 32'h0;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            regRdata_q <= '0;
        else
            regRdata_q <= regRd ? rdMux : 32'h0;
    end

    // Pins and register port
    assign lnk.sdClk     = sdClk_q;
    assign lnk.csN       = csN_q;
    assign lnk.cmdPins   = cmd_q;
    assign lnk.addr      = addr_q;
    assign lnk.bankSel   = bank_q;
    assign lnk.ctlDq     = ctlDq_q;
    assign lnk.ctlDriveN = ctlDriveN_q;
    assign regRdata      = regRdata_q;
endmodule : sdb_controller

`default_nettype wire

// File: dv/sdb_link_properties.sv
`timescale 1ns/1ns
`default_nettype none
module sdb_link_properties (
    // Observed link signals
    input wire logic               clock,
    input wire logic               rst,
    input wire logic               sdClk,
    input wire logic               csN,
    input wire sdb_pkg::sdb_cmd_e  cmdPins,
    input wire sdb_pkg::sdb_addr_t addr,
    input wire logic [1:0]         bankSel,
    input wire logic               devDriveN,
    input wire logic               ctlDriveN
);
    import sdb_pkg::*;
    logic       sd_q;
    logic [3:0] open_q;
    logic [2:0] lat_q;
    // Commands count at the link clock rise
    wire       cmdV = sdClk && !sd_q && !csN;
    wire       isLmr = cmdV && cmdPins == CMD_LMR;
    wire       isRd = cmdV && cmdPins == CMD_RD;
    wire       isAcc = isRd || cmdV && cmdPins == CMD_WR;
    wire [3:0] bankBit = 4'h1 << bankSel;
    wire [3:0] open_d = cmdV && cmdPins == CMD_ACT ? open_q | bankBit :
        cmdV && cmdPins == CMD_PRE ? (addr[10] ? 4'h0 : open_q & ~bankBit) : open_q;
    wire [2:0] lat_d = isLmr ? addr[6:4] : lat_q;
    // Open rows and loaded read latency
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            {sd_q, open_q, lat_q} <= 8'h00;
        else
            {sd_q, open_q, lat_q} <= {sdClk, open_d, lat_d};
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Data wire stays free, then the device takes it
    sequence quietThenDrive;
        devDriveN[*6] ##[2:10] !devDriveN;
    endsequence
    chk_one_driver: assert property (devDriveN || ctlDriveN) else $error("dq clash");
    chk_op_zero: assert property (isLmr |-> addr[8:7] == 2'h0) else $error("op bits");
    chk_lat_codes: assert property (isLmr |-> addr[6:4] inside {3'h2, 3'h3})
        else $error("latency code");
    chk_page_order: assert property (isLmr && addr[2:0] == 3'h7 |-> !addr[3])
        else $error("page order");
    chk_row_open: assert property (isAcc |-> open_q[bankSel]) else $error("closed");
    chk_idle_load: assert property (isLmr |-> open_q == 4'h0) else $error("rows open");
    chk_lat_two: assert property (isRd && lat_q == 3'h2 |-> quietThenDrive)
        else $error("latency two");
    chk_lat_three: assert property (isRd && lat_q == 3'h3 |-> ##8 quietThenDrive)
        else $error("latency three");
endmodule : sdb_link_properties
`default_nettype wire

// File: dv/sdram_burst_mode_and_row_activation_bench.sv
`timescale 1ns/1ns
`default_nettype none
module sdram_burst_mode_and_row_activation_bench;
    import sdb_pkg::*;
    logic        clock = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, burstBusy;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic [12:0] modeSetting;
    logic [3:0]  bankOpen;
    int          errTotal = 0, testsRun = 0;
    // System clock
    always #4 clock = ~clock;
    sdb_link_if lnk ();
    sdb_device #(.ROW_BITS(2)) sdb_device_i (.clock, .rst, .lnk, .modeSetting, .bankOpen,
        .burstBusy);
    sdb_controller sdb_controller_i (.clock, .rst, .lnk, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata);
    sdb_link_properties sdb_link_properties_i (.clock, .rst, .sdClk(lnk.sdClk), .csN(lnk.csN),
        .cmdPins(lnk.cmdPins), .addr(lnk.addr), .bankSel(lnk.bankSel),
        .devDriveN(lnk.devDriveN), .ctlDriveN(lnk.ctlDriveN));
    task report_and_stop;
        if (errTotal == 0 && testsRun > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task chk(input string what, input logic [31:0] exp, got);
        testsRun++;
        if (got !== exp)
        begin
            errTotal++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Register port: one-cycle strobes, read data one cycle later
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {regAddr, regWdata, regWr} <= {a, d, 1'b1};
        @(posedge clock);
        regWr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        {regAddr, regRd} <= {a, 1'b1};
        @(posedge clock);
        regRd <= 1'b0;
        @(posedge clock);
        d = regRdata;
    endtask : rd
    // Sends one link command, then polls busy under a bound
    task issue(input sdb_cmd_e c, input logic [31:0] a);
        logic [31:0] s;
        wr(8'h04, a);
        wr(8'h10, {29'h0, c});
        for (int i = 0; i < 300; i++)
        begin
            rd(8'h14, s);
            if (s[0] === 1'b0)
            begin
                // Let the command cross the link and settle at the far end
                repeat (16) @(posedge clock);
                return;
            end
        end
        errTotal++;
        report_and_stop();
    endtask : issue
    task mode(input logic [31:0] m, exp);
        wr(8'h00, m);
        issue(CMD_LMR, 32'h0);
        chk("mode", exp, {19'h0, modeSetting});
    endtask : mode
    task readBurst(input logic [31:0] a, exp, n);
        logic [31:0] d;
        issue(CMD_RD, a);
        rd(8'h18, d);
        chk("last word", exp, d);
        rd(8'h14, d);
        chk("count", n, {23'h0, d[24:16]});
        chk("burst busy", 32'h0, {31'h0, burstBusy});
    endtask : readBurst
    // Four words from column five, read back in sequential order
    task scSeqBurst;
        logic [31:0] d;
        rd(8'h1C, d);
        chk("unmapped", 32'h0, d);
        mode(32'h1A2, 32'h022);
        issue(CMD_ACT, 32'h2001);
        chk("bank open", 32'h2, {28'h0, bankOpen});
        wr(8'h08, 32'h100);
        wr(8'h0C, 32'h4);
        issue(CMD_WR, 32'h2005);
        readBurst(32'h2005, 32'h103, 32'h4);
    endtask : scSeqBurst
    // Refused loads, then interleaved order at latency three
    task scReload;
        mode(32'h03A, 32'h022);
        issue(CMD_PRE, 32'h400);
        mode(32'h02F, 32'h022);
        mode(32'h03A, 32'h03A);
        issue(CMD_ACT, 32'h2001);
        readBurst(32'h2005, 32'h101, 32'h4);
    endtask : scReload
    // Full page with single writes: one column written, burst ended by terminate
    task scFullPage;
        issue(CMD_PRE, 32'h400);
        chk("bank closed", 32'h0, {28'h0, bankOpen});
        mode(32'h227, 32'h227);
        issue(CMD_ACT, 32'h2001);
        wr(8'h08, 32'h200);
        wr(8'h0C, 32'h3);
        issue(CMD_WR, 32'h2003);
        wr(8'h0C, 32'h2);
        readBurst(32'h2003, 32'h103, 32'h2);
    endtask : scFullPage
    initial
    begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        scSeqBurst();
        scReload();
        scFullPage();
        report_and_stop();
    end
endmodule : sdram_burst_mode_and_row_activation_bench
`default_nettype wire
